// ### t8sc_pkg.sv
// Shared constants and types for the 8-bit single-compare timer
package t8sc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_COMPARE = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_FLAG = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned CTRL_WGM_LSB = 0;
    localparam int unsigned CTRL_COM_LSB = 4;
    localparam int unsigned CTRL_FORCE_BIT = 7;
    localparam int unsigned CTRL_CS_LSB = 8;
    localparam int unsigned FLAG_OVF_BIT = 0;
    localparam int unsigned FLAG_CMP_BIT = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Values
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam int unsigned PRESC_W = 10;

    typedef enum logic [1:0] {
        T8SC_MODE_NORMAL,
        T8SC_MODE_PHASE,
        T8SC_MODE_CTC,
        T8SC_MODE_FAST
    } t8sc_mode_t;

    typedef enum logic [1:0] {
        T8SC_COM_NONE,
        T8SC_COM_TOGGLE,
        T8SC_COM_CLEAR,
        T8SC_COM_SET
    } t8sc_com_t;

    typedef enum logic [2:0] {
        T8SC_CS_STOP,
        T8SC_CS_DIV1,
        T8SC_CS_DIV8,
        T8SC_CS_DIV64,
        T8SC_CS_DIV256,
        T8SC_CS_DIV1024,
        T8SC_CS_EXT_FALL,
        T8SC_CS_EXT_RISE
    } t8sc_cs_t;

endpackage : t8sc_pkg

// ### t8sc_prescaler.sv
// Free-running prescaler giving one-cycle divided enables
`timescale 1ns/1ps
`default_nettype none

module t8sc_prescaler (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    output logic div8_en_out,
    output logic div64_en_out,
    output logic div256_en_out,
    output logic div1024_en_out
);
    import t8sc_pkg::*;

    logic [PRESC_W-1:0] presc_r;

    // Shared by all taps, so changing the divider never waits for a restart
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            presc_r <= '0;
            div8_en_out <= 1'b0;
            div64_en_out <= 1'b0;
            div256_en_out <= 1'b0;
            div1024_en_out <= 1'b0;
        end
        else
        begin
            presc_r <= presc_r + 1'b1;
            div8_en_out <= &presc_r[2:0];
            div64_en_out <= &presc_r[5:0];
            div256_en_out <= &presc_r[7:0];
            div1024_en_out <= &presc_r[9:0];
        end
    end

endmodule : t8sc_prescaler

`default_nettype wire

// ### t8sc_timer.sv
// 8-bit timer/counter with one compare unit and an AXI4-Lite register slave
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module t8sc_timer (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic s_axi_awvalid,
    input wire logic [t8sc_pkg::ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_wready,
    output logic s_axi_bvalid,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic [t8sc_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arready,
    output logic s_axi_rvalid,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic s_axi_rready,
    input wire logic ext_count_pin_in,
    input wire logic global_irq_enable_in,
    input wire logic ovf_irq_ack_in,
    input wire logic cmp_irq_ack_in,
    output logic compare_output_out,
    output logic ovf_irq_req_out,
    output logic cmp_irq_req_out
);
    import t8sc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus write channel
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;

    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    // Fires once, in the cycle after both halves have been taken
    wire wr_fire = !s_axi_awready & !s_axi_wready & !s_axi_bvalid;
    wire wsel_ctrl = wr_fire & (aw_addr_r == OFF_CTRL);
    wire wsel_count = wr_fire & (aw_addr_r == OFF_COUNT);
    wire wsel_compare = wr_fire & (aw_addr_r == OFF_COMPARE);
    wire wsel_flag = wr_fire & (aw_addr_r == OFF_FLAG);
    wire wsel_mask = wr_fire & (aw_addr_r == OFF_MASK);
    wire wr_hit = wsel_ctrl | wsel_count | wsel_compare | wsel_flag | wsel_mask;
    wire [7:0] wbyte = w_data_r[7:0];

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_awready <= 1'b1;
            end
            if (w_hs)
            begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_wready <= 1'b1;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timer state
    t8sc_mode_t mode_r;
    t8sc_com_t com_r;
    t8sc_cs_t cs_r;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] cmp_act_r;
    logic [7:0] cmp_buf_r;
    logic down_r;
    logic down_nxt;
    logic block_r;
    logic ext_prev_r;
    logic ovf_flag_r;
    logic cmp_flag_r;
    logic ovf_mask_r;
    logic cmp_mask_r;
    logic oc_nxt;
    logic ovf_set;
    logic tick;
    logic div8_en;
    logic div64_en;
    logic div256_en;
    logic div1024_en;

    t8sc_prescaler u_presc (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .div8_en_out(div8_en),
        .div64_en_out(div64_en),
        .div256_en_out(div256_en),
        .div1024_en_out(div1024_en)
    );

    // Pin is taken as already synchronous, so a single delay stage finds edges
    always_comb
    begin
        unique case (cs_r)
            T8SC_CS_STOP: tick = 1'b0;
            T8SC_CS_DIV1: tick = 1'b1;
            T8SC_CS_DIV8: tick = div8_en;
            T8SC_CS_DIV64: tick = div64_en;
            T8SC_CS_DIV256: tick = div256_en;
            T8SC_CS_DIV1024: tick = div1024_en;
            T8SC_CS_EXT_FALL: tick = ext_prev_r & !ext_count_pin_in;
            T8SC_CS_EXT_RISE: tick = !ext_prev_r & ext_count_pin_in;
        endcase
    end

    wire pwm = (mode_r == T8SC_MODE_PHASE) || (mode_r == T8SC_MODE_FAST);
    wire at_bottom = (cnt_r == CNT_BOTTOM);
    wire at_max = (cnt_r == CNT_MAX);
    wire match = (cnt_r == cmp_act_r);
    wire [7:0] top_val = (mode_r == T8SC_MODE_CTC) ? cmp_act_r : CNT_MAX;
    wire at_top = (cnt_r == top_val);
    wire cnt_wr = wsel_count & w_strb_r[0];
    wire cmp_wr = wsel_compare & w_strb_r[0];
    wire cmp_set = tick & match & !block_r;
    wire buf_load = pwm & tick & at_max;
    wire force_hit = wsel_ctrl & w_strb_r[0] & wbyte[CTRL_FORCE_BIT] & !pwm;
    wire flag_wr = wsel_flag & w_strb_r[0];
    wire ovf_clr = (flag_wr & wbyte[FLAG_OVF_BIT]) | ovf_irq_ack_in;
    wire cmp_clr = (flag_wr & wbyte[FLAG_CMP_BIT]) | cmp_irq_ack_in;

    ////////////////////////////////////////////////////////////////////////////////
    // Count sequence
    always_comb
    begin
        cnt_nxt = cnt_r;
        down_nxt = (mode_r == T8SC_MODE_PHASE) ? down_r : 1'b0;
        ovf_set = 1'b0;
        if (tick)
        begin
            unique case (mode_r)
                T8SC_MODE_NORMAL, T8SC_MODE_FAST:
                begin
                    cnt_nxt = cnt_r + 8'h01;
                    ovf_set = at_max;
                end
                T8SC_MODE_CTC:
                begin
                    cnt_nxt = at_top ? CNT_BOTTOM : cnt_r + 8'h01;
                    ovf_set = at_max;
                end
                T8SC_MODE_PHASE:
                begin
                    // Turn at the ends; overflow is marked at bottom
                    ovf_set = at_bottom;
                    if (down_r && !at_bottom)
                    begin
                        cnt_nxt = cnt_r - 8'h01;
                    end
                    else if (!down_r && at_max)
                    begin
                        cnt_nxt = cnt_r - 8'h01;
                        down_nxt = 1'b1;
                    end
                    else
                    begin
                        cnt_nxt = cnt_r + 8'h01;
                        down_nxt = 1'b0;
                    end
                end
            endcase
        end
        if (cnt_wr)
        begin
            cnt_nxt = wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Waveform generator
    always_comb
    begin
        oc_nxt = compare_output_out;
        if (!pwm && (cmp_set || force_hit))
        begin
            unique case (com_r)
                T8SC_COM_NONE: oc_nxt = compare_output_out;
                T8SC_COM_TOGGLE: oc_nxt = !compare_output_out;
                T8SC_COM_CLEAR: oc_nxt = 1'b0;
                T8SC_COM_SET: oc_nxt = 1'b1;
            endcase
        end
        else if (mode_r == T8SC_MODE_FAST)
        begin
            // Restart from bottom overrides a match at max
            if (tick && at_max && com_r[1])
            begin
                oc_nxt = (com_r == T8SC_COM_CLEAR);
            end
            else if (cmp_set && com_r[1])
            begin
                oc_nxt = (com_r == T8SC_COM_SET);
            end
        end
        else if (mode_r == T8SC_MODE_PHASE)
        begin
            if (cmp_set && com_r[1])
            begin
                oc_nxt = (com_r == T8SC_COM_SET) ? !down_r : down_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timer registers
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            mode_r <= T8SC_MODE_NORMAL;
            com_r <= T8SC_COM_NONE;
            cs_r <= T8SC_CS_STOP;
            cnt_r <= RST_BYTE;
            cmp_act_r <= RST_BYTE;
            cmp_buf_r <= RST_BYTE;
            down_r <= 1'b0;
            block_r <= 1'b0;
            ext_prev_r <= 1'b0;
            ovf_flag_r <= 1'b0;
            cmp_flag_r <= 1'b0;
            ovf_mask_r <= 1'b0;
            cmp_mask_r <= 1'b0;
            compare_output_out <= 1'b0;
            ovf_irq_req_out <= 1'b0;
            cmp_irq_req_out <= 1'b0;
        end
        else
        begin
            ext_prev_r <= ext_count_pin_in;
            cnt_r <= cnt_nxt;
            down_r <= down_nxt;
            compare_output_out <= oc_nxt;
            // A count write arms the block; the next tick consumes it
            block_r <= cnt_wr | (block_r & !tick);
            if (wsel_ctrl && w_strb_r[0])
            begin
                mode_r <= t8sc_mode_t'(wbyte[CTRL_WGM_LSB +: 2]);
                com_r <= t8sc_com_t'(wbyte[CTRL_COM_LSB +: 2]);
            end
            if (wsel_ctrl && w_strb_r[1])
            begin
                cs_r <= t8sc_cs_t'(w_data_r[CTRL_CS_LSB +: 3]);
            end
            if (wsel_mask && w_strb_r[0])
            begin
                ovf_mask_r <= wbyte[FLAG_OVF_BIT];
                cmp_mask_r <= wbyte[FLAG_CMP_BIT];
            end
            if (cmp_wr)
            begin
                cmp_buf_r <= wbyte;
            end
            if (cmp_wr && !pwm)
            begin
                cmp_act_r <= wbyte;
            end
            else if (buf_load)
            begin
                cmp_act_r <= cmp_buf_r;
            end
            // Setting beats clearing in the same cycle
            ovf_flag_r <= ovf_set | (ovf_flag_r & !ovf_clr);
            cmp_flag_r <= cmp_set | (cmp_flag_r & !cmp_clr);
            ovf_irq_req_out <= ovf_flag_r & ovf_mask_r & global_irq_enable_in;
            cmp_irq_req_out <= cmp_flag_r & cmp_mask_r & global_irq_enable_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus read channel
    wire [7:0] cmp_view = pwm ? cmp_buf_r : cmp_act_r;
    wire [31:0] ctrl_view = {21'h0, cs_r, 2'b00, com_r, 2'b00, mode_r};
    wire rsel_ctrl = (s_axi_araddr == OFF_CTRL);
    wire rsel_count = (s_axi_araddr == OFF_COUNT);
    wire rsel_compare = (s_axi_araddr == OFF_COMPARE);
    wire rsel_flag = (s_axi_araddr == OFF_FLAG);
    wire rsel_mask = (s_axi_araddr == OFF_MASK);
    wire rd_hit = rsel_ctrl | rsel_count | rsel_compare | rsel_flag | rsel_mask;
    wire [31:0] rd_mux = rsel_ctrl ? ctrl_view :
                         rsel_count ? {24'h0, cnt_r} :
                         rsel_compare ? {24'h0, cmp_view} :
                         rsel_flag ? {30'h0, cmp_flag_r, ovf_flag_r} :
                         rsel_mask ? {30'h0, cmp_mask_r, ovf_mask_r} : 32'h0000_0000;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_write_priority: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        cnt_wr |=> cnt_r == $past(wbyte))
        else $error("count write lost to counter");

    chk_stopped_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (cs_r == T8SC_CS_STOP) && !cnt_wr |=> $stable(cnt_r))
        else $error("stopped counter moved");

    chk_normal_overflow: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        tick && mode_r == T8SC_MODE_NORMAL && at_max && !cnt_wr |=> ovf_flag_r && cnt_r == 8'h00)
        else $error("normal wrap did not flag overflow");

    chk_ctc_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        tick && mode_r == T8SC_MODE_CTC && match && !cnt_wr |=> cnt_r == 8'h00)
        else $error("clear-on-match did not clear");

    chk_match_blocked: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        block_r && tick && !cmp_flag_r |=> !cmp_flag_r)
        else $error("match not blocked after count write");

    chk_irq_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        cmp_irq_req_out |-> $past(cmp_flag_r & cmp_mask_r & global_irq_enable_in))
        else $error("compare request without its conditions");

    chk_force_noflag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        force_hit && !tick && !cmp_flag_r |=> !cmp_flag_r && cnt_r == $past(cnt_r))
        else $error("forced match touched flag or counter");

    chk_buffer_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        pwm && !buf_load && !wsel_ctrl |=> $stable(cmp_act_r))
        else $error("active compare changed away from top");

    chk_flag_set_wins: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        cmp_set && cmp_clr |=> cmp_flag_r)
        else $error("compare flag clear beat a new match");

endmodule : t8sc_timer

`default_nettype wire

// ### tb_timer8_single_compare.sv
// Self-checking bench for the 8-bit single-compare timer
`timescale 1ns/1ps
`default_nettype none

module tb_timer8_single_compare;
    import t8sc_pkg::*;

    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic s_axi_awvalid = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = 8'h00;
    logic s_axi_awready;
    logic s_axi_wvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wready;
    logic s_axi_bvalid;
    logic [1:0] s_axi_bresp;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic [ADDR_W-1:0] s_axi_araddr = 8'h00;
    logic s_axi_arready;
    logic s_axi_rvalid;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rready = 1'b0;
    logic ext_count_pin_in = 1'b0;
    logic global_irq_enable_in = 1'b0;
    logic ovf_irq_ack_in = 1'b0;
    logic cmp_irq_ack_in = 1'b0;
    logic compare_output_out;
    logic ovf_irq_req_out;
    logic cmp_irq_req_out;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] reg_list [5] = '{OFF_CTRL, OFF_COUNT, OFF_COMPARE, OFF_FLAG, OFF_MASK};
    t8sc_com_t com_list [5] = '{T8SC_COM_SET, T8SC_COM_TOGGLE, T8SC_COM_CLEAR,
                                T8SC_COM_TOGGLE, T8SC_COM_NONE};

    t8sc_timer DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wready(s_axi_wready),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bready(s_axi_bready),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_araddr(s_axi_araddr),
        .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rready(s_axi_rready),
        .ext_count_pin_in(ext_count_pin_in), .global_irq_enable_in(global_irq_enable_in),
        .ovf_irq_ack_in(ovf_irq_ack_in), .cmp_irq_ack_in(cmp_irq_ack_in),
        .compare_output_out(compare_output_out), .ovf_irq_req_out(ovf_irq_req_out),
        .cmp_irq_req_out(cmp_irq_req_out));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    // Watchdog, far above the few hundred cycles the tests need
    always @(posedge clk_sys_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            failures++;
            complete_run();
        end
    end

    task complete_run;
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    function automatic logic [31:0] ctrl_word(t8sc_mode_t m, t8sc_com_t c, t8sc_cs_t s,
                                              logic f);
        return {21'h0, s, f, 1'h0, c, 2'h0, m};
    endfunction : ctrl_word

    function automatic logic exp_force(logic cur, t8sc_com_t c);
        case (c)
            T8SC_COM_TOGGLE: return ~cur;
            T8SC_COM_CLEAR: return 1'b0;
            T8SC_COM_SET: return 1'b1;
            default: return cur;
        endcase
    endfunction : exp_force

    ////////////////////////////////////////////////////////////////////////////////
    // Master holds each channel until its own ready is sampled at an edge
    task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_p;
        logic w_p;
        @(posedge clk_sys_in);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        aw_p = 1'b1;
        w_p = 1'b1;
        while (aw_p || w_p)
        begin
            @(posedge clk_sys_in);
            if (aw_p && s_axi_awready === 1'b1)
            begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_p && s_axi_wready === 1'b1)
            begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge clk_sys_in); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys_in);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        do @(posedge clk_sys_in); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys_in); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d);
        logic [1:0] r;
        axi_read(a, d, r);
        chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask : rd

    task pin_pulses(input int k);
        repeat (k)
        begin
            @(posedge clk_sys_in) ext_count_pin_in <= 1'b1;
            repeat (3) @(posedge clk_sys_in);
            ext_count_pin_in <= 1'b0;
            repeat (3) @(posedge clk_sys_in);
        end
    endtask : pin_pulses

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] v;
        logic o;
        void'($urandom(32'h76ce));
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        foreach (reg_list[i])
        begin
            rd(reg_list[i], d);
            chk("reset value", 32'h0000_0000, d);
        end
        axi_read(8'h14, d, r);
        chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("unmapped rdata", 32'h0000_0000, d);
        axi_write(8'h14, 32'hFFFF_FFFF, r);
        chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        // Stopped counter keeps what software wrote
        repeat (4)
        begin
            v = 8'($urandom);
            wr(OFF_COUNT, {24'h0, v});
            repeat (5) @(posedge clk_sys_in);
            rd(OFF_COUNT, d);
            chk("count", {24'h0, v}, d);
            v = 8'($urandom);
            wr(OFF_COMPARE, {24'h0, v});
            rd(OFF_COMPARE, d);
            chk("compare", {24'h0, v}, d);
        end
        // Forced matches, output mode stored first
        wr(OFF_COUNT, 32'h0000_0055);
        wr(OFF_FLAG, 32'h0000_0003);
        o = 1'b0;
        foreach (com_list[i])
        begin
            wr(OFF_CTRL, ctrl_word(T8SC_MODE_NORMAL, com_list[i], T8SC_CS_STOP, 1'b0));
            wr(OFF_CTRL, ctrl_word(T8SC_MODE_NORMAL, com_list[i], T8SC_CS_STOP, 1'b1));
            o = exp_force(o, com_list[i]);
            chk("forced output", {31'h0, o}, {31'h0, compare_output_out});
        end
        rd(OFF_FLAG, d);
        chk("flag after force", 32'h0000_0000, d);
        rd(OFF_COUNT, d);
        chk("count after force", 32'h0000_0055, d);
        // External pin edges, both polarities
        wr(OFF_COUNT, 32'h0000_0000);
        wr(OFF_CTRL, ctrl_word(T8SC_MODE_NORMAL, T8SC_COM_NONE, T8SC_CS_EXT_RISE, 1'b0));
        pin_pulses(3);
        rd(OFF_COUNT, d);
        chk("rising pin count", 32'h0000_0003, d);
        wr(OFF_COUNT, 32'h0000_0000);
        wr(OFF_CTRL, ctrl_word(T8SC_MODE_NORMAL, T8SC_COM_NONE, T8SC_CS_EXT_FALL, 1'b0));
        pin_pulses(2);
        rd(OFF_COUNT, d);
        chk("falling pin count", 32'h0000_0002, d);
        // Prescaled tick, divide by eight over about 84 cycles
        wr(OFF_COUNT, 32'h0000_0000);
        wr(OFF_CTRL, ctrl_word(T8SC_MODE_NORMAL, T8SC_COM_NONE, T8SC_CS_DIV8, 1'b0));
        repeat (80) @(posedge clk_sys_in);
        wr(OFF_CTRL, ctrl_word(T8SC_MODE_NORMAL, T8SC_COM_NONE, T8SC_CS_STOP, 1'b0));
        rd(OFF_COUNT, d);
        chk("div8 count in range", 32'h1, {31'h0, (d >= 9 && d <= 12)});
        // Count write equal to compare hides the first match
        wr(OFF_COMPARE, 32'h0000_0040);
        wr(OFF_COUNT, 32'h0000_0040);
        wr(OFF_FLAG, 32'h0000_0003);
        wr(OFF_CTRL, ctrl_word(T8SC_MODE_NORMAL, T8SC_COM_NONE, T8SC_CS_DIV1, 1'b0));
        wr(OFF_CTRL, ctrl_word(T8SC_MODE_NORMAL, T8SC_COM_NONE, T8SC_CS_STOP, 1'b0));
        rd(OFF_FLAG, d);
        chk("blocked match flag", 32'h0000_0000, d);
        wr(OFF_COUNT, 32'h0000_003E);
        wr(OFF_CTRL, ctrl_word(T8SC_MODE_NORMAL, T8SC_COM_NONE, T8SC_CS_DIV1, 1'b0));
        repeat (10) @(posedge clk_sys_in);
        rd(OFF_FLAG, d);
        chk("match flag", 32'h0000_0002, d);
        // Overflow, masks, acknowledge and write-one clearing
        wr(OFF_COMPARE, 32'h0000_00E0);
        wr(OFF_MASK, 32'h0000_0003);
        global_irq_enable_in <= 1'b1;
        wr(OFF_COUNT, 32'h0000_00F0);
        repeat (40) @(posedge clk_sys_in);
        rd(OFF_FLAG, d);
        chk("overflow and match flags", 32'h0000_0003, d);
        chk("ovf request", 32'h1, {31'h0, ovf_irq_req_out});
        chk("cmp request", 32'h1, {31'h0, cmp_irq_req_out});
        @(posedge clk_sys_in) cmp_irq_ack_in <= 1'b1;
        @(posedge clk_sys_in) cmp_irq_ack_in <= 1'b0;
        wr(OFF_FLAG, 32'h0000_0000);
        rd(OFF_FLAG, d);
        chk("flags after ack", 32'h0000_0001, d);
        @(posedge clk_sys_in) global_irq_enable_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        chk("ovf request gated", 32'h0, {31'h0, ovf_irq_req_out});
        wr(OFF_FLAG, 32'h0000_0001);
        rd(OFF_FLAG, d);
        chk("flags after write one", 32'h0000_0000, d);
        // Fast PWM: compare writes go to the buffer, force has no effect
        wr(OFF_CTRL, ctrl_word(T8SC_MODE_FAST, T8SC_COM_CLEAR, T8SC_CS_STOP, 1'b0));
        wr(OFF_CTRL, ctrl_word(T8SC_MODE_FAST, T8SC_COM_CLEAR, T8SC_CS_STOP, 1'b1));
        chk("pwm force ignored", 32'h1, {31'h0, compare_output_out});
        wr(OFF_COMPARE, 32'h0000_0090);
        wr(OFF_COUNT, 32'h0000_00DF);
        wr(OFF_CTRL, ctrl_word(T8SC_MODE_FAST, T8SC_COM_CLEAR, T8SC_CS_DIV1, 1'b0));
        wr(OFF_CTRL, ctrl_word(T8SC_MODE_FAST, T8SC_COM_CLEAR, T8SC_CS_STOP, 1'b0));
        chk("fast pwm output", 32'h0, {31'h0, compare_output_out});
        rd(OFF_COMPARE, d);
        chk("compare buffer", 32'h0000_0090, d);
        // Phase PWM: new buffer value takes effect only from the top
        wr(OFF_COMPARE, 32'h0000_00F8);
        wr(OFF_COUNT, 32'h0000_00FE);
        wr(OFF_CTRL, ctrl_word(T8SC_MODE_PHASE, T8SC_COM_CLEAR, T8SC_CS_DIV1, 1'b0));
        repeat (8) @(posedge clk_sys_in);
        wr(OFF_CTRL, ctrl_word(T8SC_MODE_NORMAL, T8SC_COM_NONE, T8SC_CS_STOP, 1'b0));
        chk("phase pwm output", 32'h1, {31'h0, compare_output_out});
        rd(OFF_COUNT, d);
        chk("phase pwm count", 32'h0000_00F4, d);
        // Clear on match keeps the count at or below compare
        v = 8'(3 + $urandom_range(9));
        wr(OFF_COUNT, 32'h0000_0000);
        wr(OFF_COMPARE, {24'h0, v});
        wr(OFF_CTRL, ctrl_word(T8SC_MODE_CTC, T8SC_COM_TOGGLE, T8SC_CS_DIV1, 1'b0));
        repeat (8)
        begin
            rd(OFF_COUNT, d);
            chk("ctc count bounded", 32'h1, {31'h0, (d <= {24'h0, v})});
        end
        rd(OFF_FLAG, d);
        chk("ctc match flag", 32'h0000_0002, d & 32'h0000_0002);
        complete_run();
    end

endmodule : tb_timer8_single_compare
`default_nettype wire
